// File: include/acr_pkg.sv
// Package of register offsets, field positions and reset values for the
// accelerator control register bank. Assumes a 32-bit register port.
package acr_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_GIE      = 8'h04;
	localparam logic [7:0] ADDR_IER      = 8'h08;
	localparam logic [7:0] ADDR_ISR      = 8'h0c;
	localparam logic [7:0] ADDR_ARG_IN   = 8'h10;
	localparam logic [7:0] ADDR_ARG_HS   = 8'h14;
	localparam logic [7:0] ADDR_ARG_OUT  = 8'h18;
	localparam logic [7:0] ADDR_ARG_OHS  = 8'h1c;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_LAUNCH   = 0;
	localparam int CTRL_DONE     = 1;
	localparam int CTRL_IDLE     = 2;
	localparam int CTRL_READY    = 3;
	localparam int CTRL_RELAUNCH = 7;
	localparam int GIE_BIT       = 0;
	localparam int IRQ_DONE      = 0;
	localparam int IRQ_READY     = 1;
	localparam int HS_VLD        = 0;
	localparam int HS_ACK        = 1;
	localparam int NUM_IRQ       = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic        RST_BIT  = 1'b0;

endpackage

// File: hw/acr_irq.sv
// Interrupt status, enables and global gate for the register bank.
// Assumes one-cycle event pulses from the same clock domain.
`timescale 1ns/100ps
module acr_irq
	import acr_pkg::*;
(
	input  wire logic               i_ref_clk,
	input  wire logic               i_rst_n,
	input  wire logic [NUM_IRQ-1:0] i_event,
	input  wire logic [NUM_IRQ-1:0] i_toggle,
	input  wire logic [NUM_IRQ-1:0] i_enable,
	input  wire logic               i_global_en,
	output logic      [NUM_IRQ-1:0] o_status,
	output logic                    o_irq
);
	logic [NUM_IRQ-1:0] status;
	logic [NUM_IRQ-1:0] next_status;

	// ----------------------------------------------------------------
	// Sticky status
	// ----------------------------------------------------------------
	// An enabled event in the toggle cycle wins so no enabled event is lost
	always_comb begin
		next_status = (status ^ i_toggle) | (i_event & i_enable);
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	assign o_status = status;
	assign o_irq    = i_global_en & (|(status & i_enable));

	chk_irq_needs_gie : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_irq |-> i_global_en) else $error("irq without global enable");
	chk_event_sets_stat : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_event[0] && i_enable[0]) |=> status[0]) else $error("event lost");
endmodule

// File: hw/acr_launch.sv
// Launch request sequencer: software launch, relaunch and hold until accept.
// Assumes core strobes from the same clock domain.
`timescale 1ns/100ps
module acr_launch
	import acr_pkg::*;
(
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	input  wire logic i_launch_wr,
	input  wire logic i_relaunch_en,
	input  wire logic i_input_accept,
	input  wire logic i_completion,
	output logic      o_launch_request
);
	logic launch;
	logic next_launch;

	// ----------------------------------------------------------------
	// Launch hold
	// ----------------------------------------------------------------
	// Request stands until the core accepts it, then self-clears unless relaunch is enabled
	always_comb begin
		next_launch = launch;
		if (launch && i_input_accept) begin
			next_launch = i_relaunch_en;
		end
		if (i_launch_wr) begin
			next_launch = 1'b1;
		end
		if (i_relaunch_en && i_completion) begin
			next_launch = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			launch <= RST_BIT;
		end else begin
			launch <= next_launch;
		end
	end

	assign o_launch_request = launch;

	chk_launch_on_write : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_launch_wr |=> o_launch_request) else $error("launch not raised");
	chk_relaunch_done : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_relaunch_en && i_completion) |=> o_launch_request)
		else $error("no relaunch");
endmodule

// File: hw/acr_regs.sv
// Control and status register bank for a synthesized accelerator core.
// Assumes a single-cycle strobe register port and a core on the same clock.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps

module acr_regs
	import acr_pkg::*;
#(
	parameter int ARG_W = 32
)
(
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	input  wire logic [7:0]       i_addr,
	input  wire logic [31:0]      i_wdata,
	input  wire logic             i_wr,
	input  wire logic             i_rd,
	output logic      [31:0]      o_rdata,
	output logic                  o_launch_request,
	input  wire logic             i_completion_flag,
	input  wire logic             i_idle_flag,
	input  wire logic             i_input_accept_flag,
	output logic                  o_output_consumed_ack,
	output logic      [ARG_W-1:0] o_scalar_argument,
	output logic                  o_argument_valid_bit,
	input  wire logic             i_in_argument_acknowledge_bit,
	input  wire logic [ARG_W-1:0] i_scalar_argument,
	input  wire logic             i_out_argument_valid_bit,
	output logic                  o_argument_acknowledge_bit,
	output logic                  o_irq
);
	// Wider arguments would not fit the 32-bit register word
	if (ARG_W < 1 || ARG_W > 32) begin : g_bad_arg_w
		$error("ARG_W must be 1 to 32");
	end

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	logic wr_ctrl;
	logic wr_gie;
	logic wr_ier;
	logic wr_isr;
	logic wr_arg;
	logic wr_hs;
	logic wr_ohs;
	assign wr_ctrl = i_wr && hit(i_addr, ADDR_CTRL);
	assign wr_gie  = i_wr && hit(i_addr, ADDR_GIE);
	assign wr_ier  = i_wr && hit(i_addr, ADDR_IER);
	assign wr_isr  = i_wr && hit(i_addr, ADDR_ISR);
	assign wr_arg  = i_wr && hit(i_addr, ADDR_ARG_IN);
	assign wr_hs   = i_wr && hit(i_addr, ADDR_ARG_HS);
	assign wr_ohs  = i_wr && hit(i_addr, ADDR_ARG_OHS);

	// ----------------------------------------------------------------
	// Software state
	// ----------------------------------------------------------------
	logic               relaunch_en;
	logic               gie;
	logic [NUM_IRQ-1:0] ier;
	logic [ARG_W-1:0]   arg_in;
	logic               argument_valid_bit;
	logic               argument_acknowledge_bit;
	logic               consumed;
	logic               done_seen;
	logic               next_relaunch_en;
	logic               next_gie;
	logic [NUM_IRQ-1:0] next_ier;
	logic [ARG_W-1:0]   next_arg_in;
	logic               next_argument_valid_bit;
	logic               next_argument_acknowledge_bit;
	logic               next_consumed;
	logic               next_done_seen;

	always_comb begin
		next_relaunch_en = relaunch_en;
		next_gie         = gie;
		next_ier         = ier;
		next_arg_in      = arg_in;
		next_argument_valid_bit     = 1'b0;
		next_argument_acknowledge_bit     = 1'b0;
		next_consumed    = 1'b0;
		next_done_seen   = done_seen;
		if (wr_ctrl) begin
			next_relaunch_en = i_wdata[CTRL_RELAUNCH];
		end
		if (wr_gie) begin
			next_gie = i_wdata[GIE_BIT];
		end
		if (wr_ier) begin
			next_ier = i_wdata[NUM_IRQ-1:0];
		end
		if (wr_arg) begin
			next_arg_in = i_wdata[ARG_W-1:0];
		end
		// Valid and acknowledge are one-cycle pulses, like the core ports
		if (wr_hs) begin
			next_argument_valid_bit  = i_wdata[HS_VLD];
			next_consumed = i_wdata[HS_ACK];
		end
		if (wr_ohs) begin
			next_argument_acknowledge_bit = i_wdata[HS_ACK];
		end
		// Completion is sticky until read so a short pulse is seen
		if (i_rd && hit(i_addr, ADDR_CTRL)) begin
			next_done_seen = 1'b0;
		end
		if (i_completion_flag) begin
			next_done_seen = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			relaunch_en <= RST_BIT;
			gie         <= RST_BIT;
			ier         <= '0;
			arg_in      <= '0;
			argument_valid_bit     <= RST_BIT;
			argument_acknowledge_bit     <= RST_BIT;
			consumed    <= RST_BIT;
			done_seen   <= RST_BIT;
		end else begin
			relaunch_en <= next_relaunch_en;
			gie         <= next_gie;
			ier         <= next_ier;
			arg_in      <= next_arg_in;
			argument_valid_bit     <= next_argument_valid_bit;
			argument_acknowledge_bit     <= next_argument_acknowledge_bit;
			consumed    <= next_consumed;
			done_seen   <= next_done_seen;
		end
	end

	assign o_scalar_argument          = arg_in;
	assign o_argument_valid_bit       = argument_valid_bit;
	assign o_argument_acknowledge_bit = argument_acknowledge_bit;
	assign o_output_consumed_ack      = consumed;

	// ----------------------------------------------------------------
	// Launch and interrupts
	// ----------------------------------------------------------------
	logic [NUM_IRQ-1:0] isr;
	logic [NUM_IRQ-1:0] irq_event;
	logic [NUM_IRQ-1:0] irq_toggle;

	assign irq_event[IRQ_DONE]  = i_completion_flag;
	assign irq_event[IRQ_READY] = i_input_accept_flag;
	assign irq_toggle           = wr_isr ? i_wdata[NUM_IRQ-1:0] : '0;

	acr_launch u_launch (
		.i_ref_clk        (i_ref_clk),
		.i_rst_n          (i_rst_n),
		.i_launch_wr      (wr_ctrl && i_wdata[CTRL_LAUNCH]),
		.i_relaunch_en    (relaunch_en),
		.i_input_accept   (i_input_accept_flag),
		.i_completion     (i_completion_flag),
		.o_launch_request (o_launch_request)
	);

	acr_irq u_irq (
		.i_ref_clk   (i_ref_clk),
		.i_rst_n     (i_rst_n),
		.i_event     (irq_event),
		.i_toggle    (irq_toggle),
		.i_enable    (ier),
		.i_global_en (gie),
		.o_status    (isr),
		.o_irq       (o_irq)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Unmapped offsets and reserved bits read zero; no wait, always okay
	logic [31:0] rdata;
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = RST_WORD;
		if (i_rd) begin
			case (i_addr)
				ADDR_CTRL: begin
					next_rdata[CTRL_LAUNCH]   = o_launch_request;
					next_rdata[CTRL_DONE]     = done_seen | i_completion_flag;
					next_rdata[CTRL_IDLE]     = i_idle_flag;
					next_rdata[CTRL_READY]    = i_input_accept_flag;
					next_rdata[CTRL_RELAUNCH] = relaunch_en;
				end
				ADDR_GIE: begin
					next_rdata[GIE_BIT] = gie;
				end
				ADDR_IER: begin
					next_rdata[NUM_IRQ-1:0] = ier;
				end
				ADDR_ISR: begin
					next_rdata[NUM_IRQ-1:0] = isr;
				end
				ADDR_ARG_IN: begin
					next_rdata[ARG_W-1:0] = arg_in;
				end
				ADDR_ARG_HS: begin
					next_rdata[HS_ACK] = i_in_argument_acknowledge_bit;
				end
				ADDR_ARG_OUT: begin
					next_rdata[ARG_W-1:0] = i_scalar_argument;
				end
				ADDR_ARG_OHS: begin
					next_rdata[HS_VLD] = i_out_argument_valid_bit;
				end
				default: begin
					next_rdata = RST_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			rdata <= RST_WORD;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign o_rdata = rdata;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_idle_readback : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_CTRL) |=> o_rdata[CTRL_IDLE] == $past(i_idle_flag))
		else $error("idle readback wrong");
	chk_ready_readback : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_CTRL) |=> o_rdata[CTRL_READY] == $past(i_input_accept_flag))
		else $error("ready readback wrong");
	chk_done_readback : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_CTRL && i_completion_flag) |=> o_rdata[CTRL_DONE])
		else $error("done readback lost");
	chk_arg_out_read : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_ARG_OUT) |=> o_rdata[ARG_W-1:0] == $past(i_scalar_argument))
		else $error("output argument readback wrong");
	chk_arg_in_write : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		wr_arg |=> o_scalar_argument == $past(i_wdata[ARG_W-1:0]))
		else $error("input argument not stored");
	chk_vld_pulse : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_hs && i_wdata[HS_VLD]) |=> o_argument_valid_bit ##1 !o_argument_valid_bit)
		else $error("valid not one pulse");
	chk_ack_pulse : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_ohs && i_wdata[HS_ACK]) |=> o_argument_acknowledge_bit)
		else $error("ack not raised");
	chk_consumed_cmd : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_hs && i_wdata[HS_ACK]) |=> o_output_consumed_ack)
		else $error("consumed ack missing");
	chk_ovld_read : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_ARG_OHS) |=> o_rdata[HS_VLD] == $past(i_out_argument_valid_bit))
		else $error("output valid readback wrong");
	chk_iack_read : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_ARG_HS)
		|=> o_rdata[HS_ACK] == $past(i_in_argument_acknowledge_bit))
		else $error("input ack readback wrong");
	chk_unmapped_zero : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr > ADDR_ARG_OHS) |=> o_rdata == RST_WORD)
		else $error("unmapped read not zero");
	chk_idle_bus_zero : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!i_rd |=> o_rdata == RST_WORD) else $error("read data outside slot");
	chk_launch_readback : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_CTRL) |=> o_rdata[CTRL_LAUNCH] == $past(o_launch_request))
		else $error("launch readback wrong");
	chk_relaunch_readback : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_CTRL) |=> o_rdata[CTRL_RELAUNCH] == $past(relaunch_en))
		else $error("relaunch readback wrong");
	chk_ctrl_reserved : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_CTRL) |=> (o_rdata[6:4] == '0) && (o_rdata[31:8] == '0))
		else $error("control reserved bits not zero");
	chk_gie_readback : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_GIE) |=> o_rdata[GIE_BIT] == $past(gie))
		else $error("global enable readback wrong");
	chk_ier_readback : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_IER) |=> o_rdata[NUM_IRQ-1:0] == $past(ier))
		else $error("source enable readback wrong");
	chk_isr_reserved : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == ADDR_ISR) |=> o_rdata[31:NUM_IRQ] == '0)
		else $error("status reserved bits not zero");
endmodule

// File: testbench/acr_core_model.sv
// Behavioural model of the accelerator core behind the register bank.
// Assumes the bank's strobes and the core share one clock.
`timescale 1ns/100ps
module acr_core_model
	import acr_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_launch_request,
	input  wire logic [3:0]  i_delay,
	input  wire logic [31:0] i_arg,
	input  wire logic        i_arg_valid,
	input  wire logic        i_consumed_ack,
	input  wire logic        i_out_ack,
	output logic             o_completion,
	output logic             o_idle,
	output logic             o_accept,
	output logic             o_in_ack,
	output logic      [31:0] o_result,
	output logic             o_result_valid
);
	// ----------------------------------------------------------------
	// Run sequencing
	// ----------------------------------------------------------------
	logic       busy;
	logic [3:0] cnt;

	assign o_idle = !busy;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			busy           <= 1'b0;
			cnt            <= 4'h0;
			o_completion   <= 1'b0;
			o_accept       <= 1'b0;
			o_in_ack       <= 1'b0;
			o_result       <= 32'h0000_0000;
			o_result_valid <= 1'b0;
		end else begin
			o_accept     <= 1'b0;
			o_completion <= 1'b0;
			// Accept only while idle, as a real core would
			if (!busy && i_launch_request) begin
				busy     <= 1'b1;
				o_accept <= 1'b1;
				cnt      <= i_delay;
			end else if (busy && cnt == 4'h0) begin
				busy           <= 1'b0;
				o_completion   <= 1'b1;
				o_result       <= i_arg + 32'h0000_0001;
				o_result_valid <= 1'b1;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
			if (i_arg_valid) begin
				o_in_ack <= 1'b1;
			end else if (i_consumed_ack) begin
				o_in_ack <= 1'b0;
			end
			// Released data no longer shows the old value
			if (i_out_ack) begin
				o_result_valid <= 1'b0;
				o_result       <= ~o_result;
			end
		end
	end
endmodule

// File: testbench/acr_regs_test.sv
// Self-checking bench for the register bank with a core model behind it.
// Assumes a single 125 MHz clock and a strobe-style register port.
`timescale 1ns/100ps
module acr_regs_test
	import acr_pkg::*;
;
	logic        i_ref_clk, i_rst_n, i_wr, i_rd;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, o_scalar_argument, res, a, d;
	logic        o_launch_request, o_output_consumed_ack, o_argument_valid_bit;
	logic        o_argument_acknowledge_bit, o_irq;
	logic        done, idle, acc, in_ack, res_vld;
	logic [3:0]  delay;
	int          fail_count, check_count, n_done, n_acc, n_vld, n_cack, n_oack, k;

	acr_regs #(.ARG_W(32)) dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_launch_request(o_launch_request), .i_completion_flag(done), .i_idle_flag(idle),
		.i_input_accept_flag(acc), .o_output_consumed_ack(o_output_consumed_ack),
		.o_scalar_argument(o_scalar_argument), .o_argument_valid_bit(o_argument_valid_bit),
		.i_in_argument_acknowledge_bit(in_ack), .i_scalar_argument(res),
		.i_out_argument_valid_bit(res_vld),
		.o_argument_acknowledge_bit(o_argument_acknowledge_bit), .o_irq(o_irq));

	acr_core_model core (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_launch_request(o_launch_request), .i_delay(delay), .i_arg(o_scalar_argument),
		.i_arg_valid(o_argument_valid_bit), .i_consumed_ack(o_output_consumed_ack),
		.i_out_ack(o_argument_acknowledge_bit), .o_completion(done), .o_idle(idle),
		.o_accept(acc), .o_in_ack(in_ack), .o_result(res), .o_result_valid(res_vld));

	// ----------------------------------------------------------------
	// Clock and pulse counters
	// ----------------------------------------------------------------
	initial i_ref_clk = 1'b0;
	always #4 i_ref_clk = ~i_ref_clk;

	// Counting pulses avoids racing one-cycle outputs from the tasks
	always @(posedge i_ref_clk) begin
		if (done === 1'b1) n_done++;
		if (acc === 1'b1) n_acc++;
		if (o_argument_valid_bit === 1'b1) n_vld++;
		if (o_output_consumed_ack === 1'b1) n_cack++;
		if (o_argument_acknowledge_bit === 1'b1) n_oack++;
	end

	// ----------------------------------------------------------------
	// Tasks and expectations
	// ----------------------------------------------------------------
	function automatic logic [31:0] ctrl_word(input logic rl, input logic dn);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[CTRL_RELAUNCH] = rl;
		w[CTRL_DONE] = dn;
		w[CTRL_IDLE] = 1'b1;
		return w;
	endfunction

	task automatic stop_test();
		if (fail_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			fail_count++;
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		@(posedge i_ref_clk);
		i_addr <= ad;
		i_wdata <= dt;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
		@(posedge i_ref_clk);
		i_addr <= ad;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 dt = o_rdata;
	endtask

	task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
		logic [31:0] dt;
		rd(ad, dt);
		check(dt, exp);
	endtask

	task automatic wait_done(input int target);
		int n;
		for (n = 0; n < 300 && n_done < target; n++) @(posedge i_ref_clk);
		if (n_done < target) begin
			fail_count++;
			stop_test();
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		i_rst_n <= 1'b0; i_addr <= 8'h00; i_wdata <= 32'h0000_0000;
		i_wr <= 1'b0; i_rd <= 1'b0; delay <= 4'h0;
		k = $urandom(91427);
		repeat (3) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		rd_chk(ADDR_CTRL, ctrl_word(1'b0, 1'b0));
		for (k = 1; k <= 8; k++) rd_chk(8'(k * 4), 32'h0000_0000);
		wr(8'h40, 32'hffff_ffff);
		wr(ADDR_CTRL, 32'h0000_0070);
		rd_chk(ADDR_CTRL, ctrl_word(1'b0, 1'b0));
		wr(ADDR_GIE, 32'h0000_0001);
		wr(ADDR_IER, 32'h0000_0003);
		rd_chk(ADDR_GIE, 32'h0000_0001);
		rd_chk(ADDR_IER, 32'h0000_0003);
		wr(ADDR_ISR, 32'h0000_0002);
		rd_chk(ADDR_ISR, 32'h0000_0002);
		check(o_irq, 1'b1);
		wr(ADDR_ISR, 32'h0000_0002);
		rd_chk(ADDR_ISR, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			a = $urandom;
			delay <= 4'($urandom);
			if (i == 0) a = 32'hffff_ffff;
			wr(ADDR_ARG_IN, a);
			rd_chk(ADDR_ARG_IN, a);
			check(o_scalar_argument, a);
			wr(ADDR_CTRL, 32'h0000_0001);
			rd_chk(ADDR_CTRL, 32'h0000_0009);
			wait_done(i + 1);
			check(n_acc, i + 1);
			check(o_launch_request, 1'b0);
			rd_chk(ADDR_CTRL, ctrl_word(1'b0, 1'b1));
			rd_chk(ADDR_CTRL, ctrl_word(1'b0, 1'b0));
			rd_chk(ADDR_ISR, 32'h0000_0003);
			check(o_irq, 1'b1);
			rd_chk(ADDR_ARG_OUT, a + 32'h0000_0001);
			rd_chk(ADDR_ARG_OHS, 32'h0000_0001);
			wr(ADDR_ARG_OHS, 32'h0000_0002);
			rd_chk(ADDR_ARG_OHS, 32'h0000_0000);
			check(n_oack, i + 1);
			wr(ADDR_ISR, 32'h0000_0001);
			rd_chk(ADDR_ISR, 32'h0000_0002);
			wr(ADDR_GIE, 32'h0000_0000);
			rd_chk(ADDR_GIE, 32'h0000_0000);
			check(o_irq, 1'b0);
			wr(ADDR_GIE, 32'h0000_0001);
			wr(ADDR_ISR, 32'h0000_0002);
			rd_chk(ADDR_ISR, 32'h0000_0000);
			check(o_irq, 1'b0);
		end
		wr(ADDR_ARG_HS, 32'h0000_0001);
		rd_chk(ADDR_ARG_HS, 32'h0000_0002);
		check(n_vld, 1);
		wr(ADDR_ARG_HS, 32'h0000_0002);
		rd_chk(ADDR_ARG_HS, 32'h0000_0000);
		check(n_cack, 1);
		wr(ADDR_IER, 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_0001);
		wait_done(5);
		rd_chk(ADDR_ISR, 32'h0000_0000);
		check(o_irq, 1'b0);
		rd_chk(ADDR_CTRL, ctrl_word(1'b0, 1'b1));
		wr(ADDR_CTRL, 32'h0000_0081);
		wait_done(8);
		rd(ADDR_CTRL, d);
		check(d & 32'h0000_0080, 32'h0000_0080);
		wr(ADDR_CTRL, 32'h0000_0000);
		repeat (40) @(posedge i_ref_clk);
		k = n_acc;
		repeat (40) @(posedge i_ref_clk);
		check(n_acc, k);
		check(o_launch_request, 1'b0);
		stop_test();
	end
endmodule
